// ---- rtl/cpc_top.sv ----
// Clock source, power mode and low-power oscillator calibration control.
// Assumes oscillator ticks arrive asynchronously and are synchronised here.
//
// How it works
// R1: Source select 00 lowpower, 01 precision, 10 crystal.
// R2: Software writes zero to unused upper bits.
// R3: Software adds a dummy cycle after switch.
// R4: Power register needs prewrite key 0x01 first.
// R5: Power register needs postwrite key 0xF4 after.
// R6: Core clock is PLL divided by 2**code.
// R7: Power register resets to 0x79.
// R8: Core bit powers core; wake sets it.
// R9: Peripherals off only with core off; wake sets.
// R10: PLL off only with core, peripherals off.
// R11: LIN wake and lowpower timer stay alive.
// R12: Peripheral power-down gates memories and serial ports.
// R13: PLL-clocked timers stop when PLL off.
// R14: Crystal enable bit powers crystal circuitry.
// R15: Precision input needs bit and config bit 6.
// R16: Software adds dummy cycle after power-down.
// R17: 9-bit reference and 10-bit lowpower counters.
// R18: Reference reaching 0x1FF stops both counters.
// R19: Low four trim bits tune lowpower oscillator.
// R20: Software compares counters and steps trim.
// R21: Run lasts about 4 ms or 16 ms.
// R22: Software selects precise reference before calibrating.
// R23: Source register keyed by 0xAA then 0x55.
// R24: Calibration control: enable, clears, reset, source.
// R25: Status shows two-bit state and busy flag.
// R26: Keyed write needs preceding key; postkey commits.
// R27: Reserved divider and source codes are ignored.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps
`include "cpc_consts.svh"
module cpc_top (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   // Avalon-MM register slave
   input wire logic [31:0] I_ADDRESS,
   input wire logic I_READ,
   input wire logic I_WRITE,
   input wire logic [31:0] I_WRITEDATA,
   output logic [31:0] O_READDATA,
   output logic O_WAITREQUEST,
   // Oscillator ticks and wake events (asynchronous)
   input wire logic I_PREC_TICK,
   input wire logic I_XTAL_TICK,
   input wire logic I_LP_TICK,
   input wire logic I_WAKE,
   input wire logic I_HV_PREC_EN,
   // Clock and power controls
   output logic [1:0] O_PLL_SOURCE,
   output logic O_CORE_CLK_EN,
   output logic [2:0] O_CORE_DIVIDER,
   output logic O_CORE_ON,
   output logic O_PERIPH_ON,
   output logic O_MEM_IO_ON,
   output logic O_PLL_ON,
   output logic O_PLL_TIMERS_RUN,
   output logic O_LIN_WAKE_ON,
   output logic O_WAKE_TIMER_RUN,
   output logic O_XTAL_ON,
   output logic O_PREC_ON,
   output logic [3:0] O_LP_TRIM
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] pow;
      logic [7:0] pow_stage;
      logic [7:0] pll;
      logic [7:0] pll_stage;
      cpc_pkg::cpc_key_e pow_key;
      cpc_pkg::cpc_key_e pll_key;
      logic [7:0] trim;
      logic [7:0] cal_ctl;
      cpc_pkg::cpc_cal_e cal;
      logic [8:0] ref_cnt;
      logic [9:0] lp_cnt;
      logic [1:0] lp_div;
      logic [2:0] ref_d;
      logic [1:0] lp_d;
      logic ack;
      logic wake_d;
      logic [31:0] rdata;
   } cpc_top_s;
   cpc_top_s st_r, st_nxt;
   logic prec_s, xtal_s, lp_s, wake_s, hv_s;
   logic ref_edge, lp_edge, wr, rd, wake_edge;
   logic [7:0] wb;

   cpc_sync u_sync_prec (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .i_d(I_PREC_TICK), .o_q(prec_s));
   cpc_sync u_sync_xtal (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .i_d(I_XTAL_TICK), .o_q(xtal_s));
   cpc_sync u_sync_lp (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .i_d(I_LP_TICK), .o_q(lp_s));
   cpc_sync u_sync_wake (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .i_d(I_WAKE), .o_q(wake_s));
   cpc_sync u_sync_hv (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .i_d(I_HV_PREC_EN), .o_q(hv_s));

   cpc_clkdiv u_div (
      .I_CLK(I_CLK),
      .I_SYS_RST(I_SYS_RST),
      .i_code(st_r.pow[2:0]),
      .i_run(st_r.pow[`CPC_BIT_CORE]),
      .o_tick(O_CORE_CLK_EN)
   );

   assign wr = I_WRITE && st_r.ack;
   assign rd = I_READ && !st_r.ack;
   assign wb = I_WRITEDATA[7:0];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = (I_READ || I_WRITE) && !st_r.ack;
      // Synchronised ticks: reference selected by the calibration source bit.
      st_nxt.ref_d = {st_r.ref_d[1:0],
         st_r.cal_ctl[`CPC_BIT_CAL_XTAL] ? xtal_s : prec_s}; // R24
      st_nxt.lp_d = {st_r.lp_d[0], lp_s};
      st_nxt.wake_d = wake_s;
      ref_edge = st_r.ref_d[1] && !st_r.ref_d[2];
      lp_edge = st_r.lp_d[0] && !st_r.lp_d[1];
      wake_edge = wake_s && !st_r.wake_d;
      // Lowpower counter uses divide-by-4 against the crystal to match rates.
      if (lp_edge) begin
         st_nxt.lp_div = st_r.lp_div + 2'h1; // R17
      end
      // Calibration sequencer.
      case (st_r.cal)
         cpc_pkg::CAL_IDLE: begin
            if (st_r.cal_ctl[`CPC_BIT_CAL_EN]) begin
               st_nxt.cal = cpc_pkg::CAL_ENABLE;
            end
         end
         cpc_pkg::CAL_ENABLE: begin
            st_nxt.cal = cpc_pkg::CAL_COUNT;
            st_nxt.lp_div = '0;
         end
         cpc_pkg::CAL_COUNT: begin
            if (ref_edge) begin
               st_nxt.ref_cnt = st_r.ref_cnt + 9'h001; // R17
            end
            if (lp_edge && (!st_r.cal_ctl[`CPC_BIT_CAL_XTAL] || st_r.lp_div == 2'h3)) begin
               st_nxt.lp_cnt = st_r.lp_cnt + 10'h001; // R17
            end
            if (ref_edge && st_r.ref_cnt == `CPC_REF_DONE - 9'h001) begin
               st_nxt.cal = cpc_pkg::CAL_DONE; // R18 R21
            end
         end
         cpc_pkg::CAL_DONE: begin
            st_nxt.cal = cpc_pkg::CAL_IDLE;
            st_nxt.cal_ctl[`CPC_BIT_CAL_EN] = 1'b0; // R18
         end
         default: st_nxt.cal = cpc_pkg::CAL_IDLE;
      endcase
      // Abort or reset of the calibration logic.
      if (!st_r.cal_ctl[`CPC_BIT_CAL_EN] && st_r.cal != cpc_pkg::CAL_DONE) begin
         st_nxt.cal = cpc_pkg::CAL_IDLE; // R24
      end
      if (st_r.cal_ctl[`CPC_BIT_CAL_RST]) begin
         st_nxt.cal = cpc_pkg::CAL_IDLE;
         st_nxt.ref_cnt = '0;
         st_nxt.lp_cnt = '0;
         st_nxt.cal_ctl[`CPC_BIT_CAL_EN] = 1'b0; // R24
      end
      if (st_r.cal_ctl[`CPC_BIT_CLR_REF]) begin
         st_nxt.ref_cnt = '0;
         st_nxt.cal_ctl[`CPC_BIT_CLR_REF] = 1'b0; // R24
      end
      if (st_r.cal_ctl[`CPC_BIT_CLR_LP]) begin
         st_nxt.lp_cnt = '0;
         st_nxt.cal_ctl[`CPC_BIT_CLR_LP] = 1'b0; // R24
      end
      // Any write other than the expected key disarms a pending sequence; reads leave it armed.
      if (wr) begin
         if (I_ADDRESS != `CPC_ADDR_POW_CTL && I_ADDRESS != `CPC_ADDR_POW_POST) begin
            st_nxt.pow_key = cpc_pkg::KEY_NONE; // R26
         end
         if (I_ADDRESS != `CPC_ADDR_PLL_SEL && I_ADDRESS != `CPC_ADDR_PLL_POST) begin
            st_nxt.pll_key = cpc_pkg::KEY_NONE; // R26
         end
         if (I_ADDRESS == `CPC_ADDR_POW_PRE) begin
            st_nxt.pow_key = (I_WRITEDATA == `CPC_KEY_POW_PRE) ?
               cpc_pkg::KEY_ARMED : cpc_pkg::KEY_NONE; // R4
         end else if (I_ADDRESS == `CPC_ADDR_POW_CTL) begin
            if (st_r.pow_key == cpc_pkg::KEY_ARMED) begin
               st_nxt.pow_stage = wb;
               st_nxt.pow_key = cpc_pkg::KEY_HELD; // R26
            end else begin
               st_nxt.pow_key = cpc_pkg::KEY_NONE;
            end
         end else if (I_ADDRESS == `CPC_ADDR_POW_POST) begin
            st_nxt.pow_key = cpc_pkg::KEY_NONE;
            if (st_r.pow_key == cpc_pkg::KEY_HELD && I_WRITEDATA == `CPC_KEY_POW_POST) begin
               st_nxt.pow[7:3] = st_r.pow_stage[7:3]; // R5 R14 R15
               if (st_r.pow_stage[`CPC_BIT_CORE]) begin
                  st_nxt.pow[`CPC_BIT_PERIPH] = 1'b1; // R9
               end
               if (st_r.pow_stage[`CPC_BIT_CORE] || st_r.pow_stage[`CPC_BIT_PERIPH]) begin
                  st_nxt.pow[`CPC_BIT_PLL] = 1'b1; // R10
               end
               if (st_r.pow_stage[2:0] != `CPC_DIV_RESERVED) begin
                  st_nxt.pow[2:0] = st_r.pow_stage[2:0]; // R6 R27
               end
            end
         end else if (I_ADDRESS == `CPC_ADDR_PLL_PRE) begin
            st_nxt.pll_key = (I_WRITEDATA == `CPC_KEY_PLL_PRE) ?
               cpc_pkg::KEY_ARMED : cpc_pkg::KEY_NONE; // R23
         end else if (I_ADDRESS == `CPC_ADDR_PLL_SEL) begin
            if (st_r.pll_key == cpc_pkg::KEY_ARMED) begin
               st_nxt.pll_stage = wb;
               st_nxt.pll_key = cpc_pkg::KEY_HELD; // R26
            end else begin
               st_nxt.pll_key = cpc_pkg::KEY_NONE;
            end
         end else if (I_ADDRESS == `CPC_ADDR_PLL_POST) begin
            st_nxt.pll_key = cpc_pkg::KEY_NONE;
            if (st_r.pll_key == cpc_pkg::KEY_HELD && I_WRITEDATA == `CPC_KEY_PLL_POST
                && st_r.pll_stage[1:0] != `CPC_SRC_RESERVED) begin
               st_nxt.pll = {6'h00, st_r.pll_stage[1:0]}; // R1 R23 R27
            end
         end else if (I_ADDRESS == `CPC_ADDR_TRIM) begin
            st_nxt.trim = {4'h0, wb[3:0]}; // R19
         end else if (I_ADDRESS == `CPC_ADDR_CAL_CTL) begin
            st_nxt.cal_ctl = {3'h0, wb[4:0]}; // R24
         end
      end
      // Wake events restore the core, peripheral and PLL bits and win over a write.
      if (wake_edge) begin
         st_nxt.pow[`CPC_BIT_CORE] = 1'b1; // R8
         st_nxt.pow[`CPC_BIT_PERIPH] = 1'b1; // R9
         st_nxt.pow[`CPC_BIT_PLL] = 1'b1; // R10
      end
      // Read data.
      st_nxt.rdata = '0;
      if (rd) begin
         if (I_ADDRESS == `CPC_ADDR_POW_CTL) begin
            st_nxt.rdata = {24'h0, st_r.pow};
         end else if (I_ADDRESS == `CPC_ADDR_PLL_SEL) begin
            st_nxt.rdata = {24'h0, st_r.pll};
         end else if (I_ADDRESS == `CPC_ADDR_TRIM) begin
            st_nxt.rdata = {24'h0, st_r.trim};
         end else if (I_ADDRESS == `CPC_ADDR_CAL_CTL) begin
            st_nxt.rdata = {24'h0, st_r.cal_ctl};
         end else if (I_ADDRESS == `CPC_ADDR_CAL_STA) begin
            st_nxt.rdata = {28'h0, st_r.cal, st_r.cal_ctl[`CPC_BIT_CAL_EN],
               st_r.cal != cpc_pkg::CAL_IDLE}; // R25
         end else if (I_ADDRESS == `CPC_ADDR_REF_CNT) begin
            st_nxt.rdata = {23'h0, st_r.ref_cnt};
         end else if (I_ADDRESS == `CPC_ADDR_LP_CNT) begin
            st_nxt.rdata = {22'h0, st_r.lp_cnt};
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         st_r <= '0;
         st_r.pow <= `CPC_POW_RESET; // R7
         st_r.pll <= `CPC_PLL_RESET;
         st_r.trim <= `CPC_TRIM_RESET;
         st_r.cal_ctl <= `CPC_CAL_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign O_WAITREQUEST = (I_READ || I_WRITE) && !st_r.ack;
   assign O_READDATA = st_r.rdata;
   assign O_PLL_SOURCE = st_r.pll[1:0]; // R1
   assign O_CORE_DIVIDER = st_r.pow[2:0]; // R6
   assign O_CORE_ON = st_r.pow[`CPC_BIT_CORE]; // R8
   assign O_PERIPH_ON = st_r.pow[`CPC_BIT_PERIPH];
   assign O_MEM_IO_ON = st_r.pow[`CPC_BIT_PERIPH]; // R12
   assign O_PLL_ON = st_r.pow[`CPC_BIT_PLL];
   assign O_PLL_TIMERS_RUN = st_r.pow[`CPC_BIT_PLL]; // R13
   assign O_LIN_WAKE_ON = 1'b1; // R11
   assign O_WAKE_TIMER_RUN = 1'b1; // R11
   assign O_XTAL_ON = st_r.pow[`CPC_BIT_XTAL]; // R14
   assign O_PREC_ON = st_r.pow[`CPC_BIT_PREC] && hv_s; // R15
   assign O_LP_TRIM = st_r.trim[3:0]; // R19

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_pow_reset: assert property (@(posedge I_CLK) $fell(I_SYS_RST) |-> st_r.pow == 8'h79) // R7
      else $error("power control not at reset value");
   a_wake_core: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // R8
      wake_edge |=> O_CORE_ON && O_PERIPH_ON && O_PLL_ON)
      else $error("wake did not restore power bits");
   a_periph_dep: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // R9
      O_CORE_ON |-> O_PERIPH_ON && O_PLL_ON)
      else $error("peripherals or PLL off with core on");
   a_pll_dep: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // R10
      O_PERIPH_ON |-> O_PLL_ON)
      else $error("PLL off with peripherals on");
   a_src_valid: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // R27
      O_PLL_SOURCE != 2'h3)
      else $error("reserved clock source selected");
   a_unkeyed_pow: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // R26
      (wr && I_ADDRESS == `CPC_ADDR_POW_CTL && st_r.pow_key != cpc_pkg::KEY_ARMED)
      |=> st_r.pow_key == cpc_pkg::KEY_NONE)
      else $error("unkeyed power write accepted");
   a_cal_stop: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // R18
      st_r.cal == cpc_pkg::CAL_DONE |-> st_r.ref_cnt == 9'h1ff ##1 $stable(st_r.ref_cnt))
      else $error("calibration stopped at wrong count");
   a_prec_gate: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // R15
      O_PREC_ON |-> hv_s && st_r.pow[7])
      else $error("precision input on without both enables");
   a_trim_low: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // R19
      st_r.trim[7:4] == 4'h0)
      else $error("trim upper bits not zero");
   a_core_tick_off: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // R8
      !O_CORE_ON |=> !O_CORE_CLK_EN)
      else $error("core clock enable pulsed with core off");
   a_src_keyed: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // R26
      $changed(O_PLL_SOURCE) |-> $past(wr) && $past(I_ADDRESS) == `CPC_ADDR_PLL_POST)
      else $error("clock source changed without postwrite key");
   a_div_keyed: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // R26
      $changed(O_CORE_DIVIDER) |-> $past(wr) && $past(I_ADDRESS) == `CPC_ADDR_POW_POST)
      else $error("core divider changed without postwrite key");
   a_div_valid: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // R27
      O_CORE_DIVIDER != `CPC_DIV_RESERVED)
      else $error("reserved core divider selected");
   a_ref_frozen: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // R18
      st_r.cal != cpc_pkg::CAL_COUNT && st_r.cal_ctl[3:1] == 3'h0
      |=> $stable(st_r.ref_cnt))
      else $error("reference counter moved outside counting");
   a_lp_frozen: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // R18
      st_r.cal != cpc_pkg::CAL_COUNT && st_r.cal_ctl[3:1] == 3'h0
      |=> $stable(st_r.lp_cnt))
      else $error("lowpower counter moved outside counting");
   a_mem_off: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // R12
      !O_PERIPH_ON |-> !O_MEM_IO_ON)
      else $error("memories powered with peripherals off");
   a_timer_stop: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // R13
      !O_PLL_ON |-> !O_PLL_TIMERS_RUN)
      else $error("PLL timers running with PLL off");
endmodule // cpc_top

// ---- rtl/cpc_consts.svh ----
// Constants of the clock, power and calibration control block.
// Assumes byte addresses on a 32-bit Avalon-MM register port.
`ifndef CPC_CONSTS_SVH
`define CPC_CONSTS_SVH
`define CPC_ADDR_POW_PRE 32'hffff0404
`define CPC_ADDR_POW_CTL 32'hffff0408
`define CPC_ADDR_POW_POST 32'hffff040c
`define CPC_ADDR_PLL_PRE 32'hffff0410
`define CPC_ADDR_PLL_SEL 32'hffff0414
`define CPC_ADDR_PLL_POST 32'hffff0418
`define CPC_ADDR_TRIM 32'hffff042c
`define CPC_ADDR_CAL_CTL 32'hffff0440
`define CPC_ADDR_CAL_STA 32'hffff0444
`define CPC_ADDR_REF_CNT 32'hffff0448
`define CPC_ADDR_LP_CNT 32'hffff044c
`define CPC_KEY_POW_PRE 32'h00000001
`define CPC_KEY_POW_POST 32'h000000f4
`define CPC_KEY_PLL_PRE 32'h000000aa
`define CPC_KEY_PLL_POST 32'h00000055
`define CPC_POW_RESET 8'h79
`define CPC_PLL_RESET 8'h00
`define CPC_TRIM_RESET 8'h08
`define CPC_CAL_RESET 8'h00
`define CPC_BIT_CORE 3
`define CPC_BIT_PERIPH 4
`define CPC_BIT_PLL 5
`define CPC_BIT_XTAL 6
`define CPC_BIT_PREC 7
`define CPC_BIT_CAL_EN 0
`define CPC_BIT_CLR_REF 1
`define CPC_BIT_CLR_LP 2
`define CPC_BIT_CAL_RST 3
`define CPC_BIT_CAL_XTAL 4
`define CPC_DIV_RESERVED 3'h7
`define CPC_SRC_RESERVED 2'h3
`define CPC_REF_DONE 9'h1ff
`define CPC_PLL_HZ 20480000
`endif

// ---- rtl/cpc_pkg.sv ----
// Types of the clock, power and calibration control block.
// Assumes the constants header is included by the design files.
package cpc_pkg;
   typedef enum logic [1:0] {
      SRC_LOWPOWER,
      SRC_PRECISION,
      SRC_CRYSTAL,
      SRC_RESERVED
   } cpc_src_e;
   typedef enum logic [1:0] {
      CAL_IDLE,
      CAL_ENABLE,
      CAL_COUNT,
      CAL_DONE
   } cpc_cal_e;
   typedef enum logic [1:0] {
      KEY_NONE,
      KEY_ARMED,
      KEY_HELD
   } cpc_key_e;
endpackage

// ---- rtl/cpc_sync.sv ----
// Two-flop level synchroniser.
// Assumes the input comes from another clock domain.
`timescale 1ns/100ps
module cpc_sync (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   // Level
   input wire logic i_d,
   output logic o_q
);
   typedef struct packed {
      logic s1;
      logic s2;
   } cpc_sync_s;
   cpc_sync_s st_r, st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = i_d;
      st_nxt.s2 = st_r.s1;
   end
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign o_q = st_r.s2;
endmodule // cpc_sync

// ---- rtl/cpc_clkdiv.sv ----
// Core clock divider: one enable pulse every 2**code system clocks.
// Assumes the system clock stands for the PLL output.
`timescale 1ns/100ps
module cpc_clkdiv (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   // Control
   input wire logic [2:0] i_code,
   input wire logic i_run,
   // Output
   output logic o_tick
);
   typedef struct packed {
      logic [6:0] cnt;
      logic tick;
   } cpc_div_s;
   cpc_div_s st_r, st_nxt;
   logic [6:0] last;
   always_comb begin
      last = 7'((8'h01 << i_code) - 8'h01);
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (!i_run) begin
         st_nxt.cnt = '0;
      end else if (st_r.cnt >= last) begin
         st_nxt.cnt = '0;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 7'h01;
      end
   end
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign o_tick = st_r.tick;
endmodule // cpc_clkdiv

// ---- verification/tb_cpc_top.sv ----
// Self-checking bench of the clock, power and calibration control block.
// Assumes the design files and the constants header are compiled before it.
`timescale 1ns/100ps
`include "cpc_consts.svh"
module tb_cpc_top;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk, rst, rd, wr, prec, xtal, lp, wake, hv;
   logic [31:0] addr, wdata, rdata, val;
   logic wait_req, core_en, core_on, per_on, mem_on, pll_on, tmr_run, lin_on, wt_run;
   logic xtal_on, prec_on;
   logic [1:0] src;
   logic [2:0] div;
   logic [3:0] trim;
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;
   int tick_cnt = 0;

   cpc_top i_cpc_top (
      .I_CLK(clk), .I_SYS_RST(rst), .I_ADDRESS(addr), .I_READ(rd), .I_WRITE(wr),
      .I_WRITEDATA(wdata), .O_READDATA(rdata), .O_WAITREQUEST(wait_req),
      .I_PREC_TICK(prec), .I_XTAL_TICK(xtal), .I_LP_TICK(lp), .I_WAKE(wake),
      .I_HV_PREC_EN(hv), .O_PLL_SOURCE(src), .O_CORE_CLK_EN(core_en),
      .O_CORE_DIVIDER(div), .O_CORE_ON(core_on), .O_PERIPH_ON(per_on),
      .O_MEM_IO_ON(mem_on), .O_PLL_ON(pll_on), .O_PLL_TIMERS_RUN(tmr_run),
      .O_LIN_WAKE_ON(lin_on), .O_WAKE_TIMER_RUN(wt_run), .O_XTAL_ON(xtal_on),
      .O_PREC_ON(prec_on), .O_LP_TRIM(trim)
   );

   // ----------------------------------------
   // Clock, oscillator ticks and timeout
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Precision and low-power ticks share one rate; the crystal runs four times slower.
   always @(posedge clk) begin
      tick_cnt <= tick_cnt + 1;
      prec <= tick_cnt[2];
      lp <= tick_cnt[2];
      xtal <= tick_cnt[4];
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         num_errors++;
         end_of_test();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_of_test();
      if (num_errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One Avalon transfer; waitrequest and read data are taken at the rising edge.
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge clk);
         n++;
      end while (wait_req !== 1'b0 && n < 50);
      val = rdata;
      if (n >= 50) check("waitrequest", 32'h1, 32'h0);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(name, val, exp);
   endtask

   task automatic pow_w(input logic [7:0] v);
      bus(1'b1, `CPC_ADDR_POW_PRE, `CPC_KEY_POW_PRE);
      bus(1'b1, `CPC_ADDR_POW_CTL, {24'h0, v});
      bus(1'b1, `CPC_ADDR_POW_POST, `CPC_KEY_POW_POST);
      repeat (2) @(negedge clk);
   endtask

   task automatic pll_w(input logic [7:0] v);
      bus(1'b1, `CPC_ADDR_PLL_PRE, `CPC_KEY_PLL_PRE);
      bus(1'b1, `CPC_ADDR_PLL_SEL, {24'h0, v});
      bus(1'b1, `CPC_ADDR_PLL_POST, `CPC_KEY_PLL_POST);
      repeat (2) @(negedge clk);
   endtask

   // Measures the spacing of core clock enables after the divider has settled.
   task automatic gap_chk(input int code);
      int n;
      n = 0;
      repeat (3) begin
         @(negedge clk);
         n = 1;
         while (core_en !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
         end
      end
      check("core_gap", n, 32'h1 << code);
   endtask

   task automatic cal_run(input logic [31:0] ctl);
      int n;
      bus(1'b1, `CPC_ADDR_CAL_CTL, 32'h06);
      rd_chk("ref_clear", `CPC_ADDR_REF_CNT, 32'h0);
      rd_chk("lp_clear", `CPC_ADDR_LP_CNT, 32'h0);
      bus(1'b1, `CPC_ADDR_CAL_CTL, ctl);
      n = 0;
      do begin
         bus(1'b0, `CPC_ADDR_CAL_STA, 32'h0);
         n++;
      end while (val[3:2] !== 2'b10 && n < 100);
      check("cal_counting", val, 32'hb);
      n = 0;
      do begin
         bus(1'b0, `CPC_ADDR_CAL_STA, 32'h0);
         n++;
      end while (val[0] !== 1'b0 && n < 8000);
      check("cal_done", val, 32'h0);
      rd_chk("ref_final", `CPC_ADDR_REF_CNT, 32'h1ff);
      bus(1'b0, `CPC_ADDR_LP_CNT, 32'h0);
      check("lp_near_ref", {31'h0, val > 32'h1fc && val < 32'h202}, 32'h1);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int n;
      rst = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      addr = 32'h0;
      wdata = 32'h0;
      prec = 1'b0;
      xtal = 1'b0;
      lp = 1'b0;
      wake = 1'b0;
      hv = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd_chk("power_rst", `CPC_ADDR_POW_CTL, 32'h79);
      rd_chk("pll_rst", `CPC_ADDR_PLL_SEL, 32'h0);
      rd_chk("trim_rst", `CPC_ADDR_TRIM, 32'h8);
      rd_chk("sta_rst", `CPC_ADDR_CAL_STA, 32'h0);
      rd_chk("unmapped", 32'hffff0500, 32'h0);
      check("div_rst", div, 32'h1);
      check("pwr_rst", {core_on, per_on, pll_on, xtal_on, prec_on}, 32'h1e);
      // Unkeyed, wrongly keyed and interrupted sequences leave the register alone.
      bus(1'b1, `CPC_ADDR_POW_CTL, 32'h7b);
      bus(1'b1, `CPC_ADDR_POW_PRE, 32'h2);
      bus(1'b1, `CPC_ADDR_POW_CTL, 32'h7b);
      bus(1'b1, `CPC_ADDR_POW_POST, `CPC_KEY_POW_POST);
      bus(1'b1, `CPC_ADDR_POW_PRE, `CPC_KEY_POW_PRE);
      bus(1'b1, `CPC_ADDR_POW_CTL, 32'h7b);
      check("div_before_post", div, 32'h1);
      bus(1'b1, `CPC_ADDR_POW_POST, 32'hf5);
      bus(1'b1, `CPC_ADDR_POW_PRE, `CPC_KEY_POW_PRE);
      bus(1'b1, `CPC_ADDR_POW_CTL, 32'h7b);
      bus(1'b1, `CPC_ADDR_TRIM, 32'h8);
      bus(1'b1, `CPC_ADDR_POW_POST, `CPC_KEY_POW_POST);
      rd_chk("power_locked", `CPC_ADDR_POW_CTL, 32'h79);
      rd_chk("key_read", `CPC_ADDR_POW_PRE, 32'h0);
      for (int c = 0; c < 7; c++) begin
         pow_w(8'h78 | 8'(c));
         check("core_div", div, 32'(c));
         gap_chk(c);
      end
      pow_w(8'h7f);
      rd_chk("div_reserved", `CPC_ADDR_POW_CTL, 32'h7e);
      pow_w(8'h69);
      rd_chk("periph_forced", `CPC_ADDR_POW_CTL, 32'h79);
      pow_w(8'h51);
      rd_chk("pll_forced", `CPC_ADDR_POW_CTL, 32'h71);
      check("core_off", {core_on, per_on, pll_on}, 32'h3);
      pow_w(8'h41);
      check("all_off", {core_on, per_on, mem_on, pll_on, tmr_run, lin_on, wt_run}, 32'h3);
      n = 0;
      repeat (64) begin
         @(negedge clk);
         if (core_en !== 1'b0) n++;
      end
      check("core_clk_off", n, 32'h0);
      @(posedge clk);
      wake <= 1'b1;
      repeat (6) @(posedge clk);
      check("wake_on", {core_on, per_on, pll_on}, 32'h7);
      wake <= 1'b0;
      rd_chk("wake_power", `CPC_ADDR_POW_CTL, 32'h79);
      pow_w(8'h39);
      check("xtal_off", xtal_on, 32'h0);
      pow_w(8'hf9);
      check("xtal_on", xtal_on, 32'h1);
      check("prec_no_hv", prec_on, 32'h0);
      @(posedge clk);
      hv <= 1'b1;
      repeat (6) @(posedge clk);
      check("prec_hv", prec_on, 32'h1);
      for (int s = 0; s < 3; s++) begin
         pll_w(8'(s));
         check("pll_src", src, 32'(s));
      end
      pll_w(8'h03);
      rd_chk("src_reserved", `CPC_ADDR_PLL_SEL, 32'h2);
      bus(1'b1, `CPC_ADDR_POW_PRE, `CPC_KEY_POW_PRE);
      bus(1'b1, `CPC_ADDR_PLL_SEL, 32'h1);
      bus(1'b1, `CPC_ADDR_PLL_POST, `CPC_KEY_PLL_POST);
      rd_chk("pll_locked", `CPC_ADDR_PLL_SEL, 32'h2);
      bus(1'b1, `CPC_ADDR_TRIM, 32'h0c);
      @(negedge clk);
      check("trim", trim, 32'hc);
      rd_chk("trim_read", `CPC_ADDR_TRIM, 32'h0c);
      pll_w(8'h01);
      cal_run(32'h01);
      cal_run(32'h11);
      bus(1'b1, `CPC_ADDR_CAL_CTL, 32'h01);
      repeat (200) @(posedge clk);
      bus(1'b1, `CPC_ADDR_CAL_CTL, 32'h00);
      repeat (4) @(negedge clk);
      bus(1'b0, `CPC_ADDR_CAL_STA, 32'h0);
      check("cal_abort", val[1:0], 32'h0);
      bus(1'b1, `CPC_ADDR_CAL_CTL, 32'h01);
      repeat (200) @(posedge clk);
      bus(1'b1, `CPC_ADDR_CAL_CTL, 32'h08);
      repeat (4) @(negedge clk);
      rd_chk("cal_reset_sta", `CPC_ADDR_CAL_STA, 32'h0);
      rd_chk("cal_reset_ref", `CPC_ADDR_REF_CNT, 32'h0);
      rd_chk("cal_reset_lp", `CPC_ADDR_LP_CNT, 32'h0);
      end_of_test();
   end
endmodule // tb_cpc_top
